// file: design/pic_top.sv
// Purpose: prioritized interrupt controller in front of the core
// Assumes: requests are levels held by the sources until serviced
// Notes: core handshake is accept_valid / core_ack
//
// How it works
// RULE_01 - vector address is low 16 bits, 2 or 4
// RULE_02 - serial0 four requests, vectors 52-55, one bit
// RULE_03 - serial1 four requests, vectors 56-59, one bit
// RULE_04 - scheme 1: main mask alone governs masking
// RULE_05 - scheme 0: main and user mask together
// RULE_06 - nonmaskable accepted always outside reset
// RULE_07 - disabled request never reaches the selection
// RULE_08 - highest ranked wins, others stay pending
// RULE_09 - equal level ties broken by vector order
// RULE_10 - level 1 beats level 0 always
// RULE_11 - scheme 1: main mask 1 holds all maskable
// RULE_12 - scheme 0: level 0 masked by main mask
// RULE_13 - scheme 0: level 1 masked only both set
// RULE_14 - scheme 0: main mask 0 accepts any
// RULE_15 - core finishes current instruction before handling
// RULE_16 - core stacks counter and flags
// RULE_17 - scheme 1: main mask set after save
// RULE_18 - scheme 0: both masks set after save
// RULE_19 - vector address of accepted interrupt produced
// RULE_20 - default order smaller vector first after reset
// RULE_21 - nonmaskable vector 7, selectable pin edge
// RULE_22 - timer, converter vectors; reserved never raised
// RULE_23 - masked request held and re-evaluated each cycle
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pic_top
   import pic_pkg::*;
#(
   parameter int NSRC = PIC_NSRC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt sources
   input wire logic nmi_pin,
   input wire logic [NSRC-1:0] src_req,
   // core side
   input wire logic core_insn_end,
   input wire logic core_ack,
   output logic accept_valid,
   output logic accept_nmi,
   output logic [7:0] accept_vector,
   output logic [15:0] accept_vec_addr,
   output logic [1:0] processor_flags_word
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0] system_control_word;
   logic [7:0] priority_reg_second;
   logic [NSRC-1:0] src_enable;
   logic nmi_pin_q;
   logic nmi_pend;
   logic wr_aw_held;
   logic wr_w_held;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;

   wire mask_scheme_select = system_control_word[PIC_SYS_SCHEME];
   wire nonmaskable_edge_select = system_control_word[PIC_SYS_NMIEDGE];
   wire adv_mode = system_control_word[PIC_SYS_ADVMODE];
   wire main_mask = processor_flags_word[PIC_FLG_MAIN];
   wire user_mask_bit = processor_flags_word[PIC_FLG_USER];

   // ------------------------------------------------------------
   // request qualification and selection
   // ------------------------------------------------------------
   logic [NSRC-1:0] src_live;
   logic [NSRC-1:0] src_level;
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         if (gi < PIC_NUSED) begin : g_used
            assign src_live[gi] = src_req[gi] & src_enable[gi]; // RULE_07
            assign src_level[gi] =
               priority_reg_second[PIC_GRP_TAB[gi]]; // RULE_02 RULE_03
         end else begin : g_rsv
            assign src_live[gi] = 1'b0; // RULE_22
            assign src_level[gi] = 1'b0;
         end
      end
   endgenerate

   wire [NSRC-1:0] live_hi = src_live & src_level;
   wire [NSRC-1:0] live_lo = src_live & ~src_level;

   // lowest index first gives the default vector order
   function automatic logic [NSRC:0] pic_pick(input logic [NSRC-1:0] v);
      logic [NSRC:0] r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, NSRC'(i)};
         end
      end
      return r;
   endfunction : pic_pick

   wire [NSRC:0] pick_hi = pic_pick(live_hi); // RULE_09 RULE_20
   wire [NSRC:0] pick_lo = pic_pick(live_lo);
   wire hi_any = pick_hi[NSRC];
   wire lo_any = pick_lo[NSRC];
   wire [NSRC-1:0] win_idx = hi_any ? pick_hi[NSRC-1:0]
                                    : pick_lo[NSRC-1:0]; // RULE_10 RULE_08
   wire win_level = hi_any;
   wire win_any = hi_any | lo_any;

   // masking, both schemes
   wire hi_ok = mask_scheme_select ? ~main_mask // RULE_04 RULE_11
              : (~main_mask | ~user_mask_bit); // RULE_05 RULE_13 RULE_14
   wire lo_ok = ~main_mask; // RULE_12 RULE_11
   wire win_ok = win_any & (win_level ? hi_ok : lo_ok);
   // a level 0 winner that is masked must not hide an unmasked level 1
   wire take_ok = hi_any ? hi_ok : win_ok; // RULE_23

   wire [7:0] win_vec = PIC_VEC_TAB[win_idx[4:0]];

   // nonmaskable edge on the selected polarity
   wire nmi_edge = nonmaskable_edge_select ? (nmi_pin & ~nmi_pin_q)
                                           : (~nmi_pin & nmi_pin_q); // RULE_21

   // accept at instruction boundary only
   wire start_take = ~accept_valid & core_insn_end
                     & (nmi_pend | take_ok); // RULE_15 RULE_06
   wire take_nmi = nmi_pend;
   wire [7:0] next_vec = take_nmi ? PIC_VEC_NMI : win_vec; // RULE_19
   wire [15:0] next_vaddr = adv_mode
      ? 16'({8'h00, next_vec} << PIC_ADV_SHIFT)
      : 16'({8'h00, next_vec} << PIC_NORM_SHIFT); // RULE_01

   // ------------------------------------------------------------
   // AXI4-Lite decode
   // ------------------------------------------------------------
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire aw_have = wr_aw_held | aw_take;
   wire w_have = wr_w_held | w_take;
   wire [7:0] wa = wr_aw_held ? wr_addr : s_axi_awaddr;
   wire [31:0] wd = wr_w_held ? wr_data : s_axi_wdata;
   wire do_wr = aw_have & w_have & ~s_axi_bvalid;
   wire wr_sys = do_wr & (wa == PIC_OFS_SYSCTL) & s_axi_wstrb[0];
   wire wr_flg = do_wr & (wa == PIC_OFS_FLAGS) & s_axi_wstrb[0];
   wire wr_pri = do_wr & (wa == PIC_OFS_PRIO) & s_axi_wstrb[0];
   wire wr_ena = do_wr & (wa == PIC_OFS_ENABLE);
   wire wr_hit = (wa == PIC_OFS_SYSCTL) | (wa == PIC_OFS_FLAGS)
               | (wa == PIC_OFS_PRIO) | (wa == PIC_OFS_ENABLE);
   logic [31:0] ena_wide;
   always_comb begin
      ena_wide = 32'(src_enable);
      for (int b = 0; b < 4; b++) begin
         if (s_axi_wstrb[b]) begin
            ena_wide[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   end

   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [31:0] rd_status = {24'h000000, accept_vector};
   logic [31:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         PIC_OFS_SYSCTL: rd_val = 32'(system_control_word);
         PIC_OFS_FLAGS: rd_val = 32'(processor_flags_word);
         PIC_OFS_PRIO: rd_val = 32'(priority_reg_second);
         PIC_OFS_ENABLE: rd_val = 32'(src_enable);
         PIC_OFS_STATUS: rd_val = {rd_status[31:10], nmi_pend,
                                   accept_valid, rd_status[7:0]};
         PIC_OFS_PEND: rd_val = 32'(src_live);
         default: begin
            rd_val = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // mask update after context save, else software write
   logic [1:0] next_flags;
   always_comb begin
      next_flags = processor_flags_word;
      if (wr_flg) begin
         next_flags = wd[1:0];
      end
      if (accept_valid & core_ack) begin
         next_flags[PIC_FLG_MAIN] = 1'b1; // RULE_17 RULE_18
         if (!mask_scheme_select) begin
            next_flags[PIC_FLG_USER] = 1'b1; // RULE_18
         end
      end
   end

   // ------------------------------------------------------------
   // sequential
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PIC_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= PIC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         wr_aw_held <= 1'b0;
         wr_w_held <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
      end else begin
         if (do_wr) begin
            wr_aw_held <= 1'b0;
            wr_w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               wr_aw_held <= 1'b1;
               wr_addr <= s_axi_awaddr;
               s_axi_awready <= 1'b0;
            end
            if (w_take) begin
               wr_w_held <= 1'b1;
               wr_data <= s_axi_wdata;
               s_axi_wready <= 1'b0;
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         system_control_word <= PIC_SYS_RST;
         processor_flags_word <= PIC_FLG_RST;
         priority_reg_second <= PIC_PRIO_RST; // RULE_20
         src_enable <= NSRC'(PIC_ENA_RST);
      end else begin
         if (wr_sys) begin
            system_control_word <= wd[2:0];
         end
         if (wr_pri) begin
            priority_reg_second <= wd[7:0];
         end
         if (wr_ena) begin
            src_enable <= ena_wide[NSRC-1:0];
         end
         processor_flags_word <= next_flags;
      end
   end

   // edge latch: a new edge wins over the clear of acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // follow the pin in reset so release shows no false edge
         nmi_pin_q <= nmi_pin;
         nmi_pend <= 1'b0;
      end else begin
         nmi_pin_q <= nmi_pin;
         if (nmi_edge) begin
            nmi_pend <= 1'b1; // RULE_06 RULE_21
         end else if (accept_valid & core_ack & accept_nmi) begin
            nmi_pend <= 1'b0;
         end
      end
   end

   // accepted interrupt stands until the core stacks context
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_valid <= 1'b0;
         accept_nmi <= 1'b0;
         accept_vector <= 8'h00;
         accept_vec_addr <= 16'h0000;
      end else if (start_take) begin
         accept_valid <= 1'b1;
         accept_nmi <= take_nmi;
         accept_vector <= next_vec; // RULE_19
         accept_vec_addr <= next_vaddr; // RULE_01
      end else if (core_ack) begin
         accept_valid <= 1'b0; // RULE_16
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_DISABLED_NEVER: assert property ( // RULE_07
      start_take & ~take_nmi |-> src_enable[win_idx[4:0]])
      else $error("disabled source accepted");
   AST_HI_BEATS_LO: assert property ( // RULE_10
      win_any & hi_any |-> src_live[win_idx[4:0]] & src_level[win_idx[4:0]])
      else $error("level 0 beat level 1");
   AST_MAIN_MASK_HOLDS: assert property ( // RULE_11
      mask_scheme_select & main_mask & ~nmi_pend |-> ~start_take)
      else $error("maskable taken under main mask");
   AST_BOTH_MASK_HOLDS: assert property ( // RULE_13
      ~mask_scheme_select & main_mask & user_mask_bit & ~nmi_pend
      |-> ~start_take)
      else $error("maskable taken under both masks");
   AST_LVL1_PASSES: assert property ( // RULE_13
      ~mask_scheme_select & main_mask & ~user_mask_bit & hi_any
      & ~accept_valid & core_insn_end |=> accept_valid)
      else $error("level 1 held under user mask clear");
   AST_MASK_SET: assert property ( // RULE_18
      accept_valid & core_ack & ~mask_scheme_select & ~wr_flg
      |=> processor_flags_word == 2'h3)
      else $error("masks not set after save");
   AST_NMI_TAKEN: assert property ( // RULE_06
      nmi_pend & ~accept_valid & core_insn_end
      |=> accept_valid & accept_nmi & accept_vector == PIC_VEC_NMI)
      else $error("nonmaskable not accepted");
   AST_VEC_ADDR: assert property ( // RULE_01
      start_take & adv_mode
      |=> accept_vec_addr == 16'($past(next_vec)) * 16'h0004)
      else $error("advanced vector address wrong");
   AST_HOLD_PEND: assert property ( // RULE_15
      accept_valid & ~core_ack |=> accept_valid & $stable(accept_vector))
      else $error("accepted interrupt dropped");

   COV_NMI: cover property (start_take & take_nmi);
   COV_LVL1: cover property (start_take & hi_any & ~take_nmi);
   COV_SCHEME0: cover property (start_take & ~mask_scheme_select
                                & main_mask);
   COV_WRITE: cover property (s_axi_bvalid & s_axi_bready);
endmodule : pic_top

// file: pkg/pic_pkg.sv
// Purpose: constants for the prioritized interrupt controller
// Assumes: 50 MHz core clock, AXI4-Lite register access
// Notes: vector numbers, register offsets and field positions
package pic_pkg;
   // ------------------------------------------------------------
   // vectors
   // ------------------------------------------------------------
   localparam int PIC_NSRC = 18;
   localparam logic [7:0] PIC_VEC_NMI = 8'h07;
   // source order is the default order, smaller vector first
   localparam logic [7:0] PIC_VEC_TAB [PIC_NSRC] = '{
      8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2A,
      8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B,
      8'h3C, 8'h00, 8'h00, 8'h00};
   localparam int PIC_NUSED = 15;
   // priority-bit group per source, index into priority_reg_second
   localparam int PIC_GRP_TAB [PIC_NSRC] = '{
      7, 7, 7, 6, 6, 6, 3, 3, 3, 3, 2, 2, 2, 2, 1, 0, 0, 0};
   localparam int PIC_ADDR_W = 16;
   localparam int PIC_NORM_SHIFT = 1;
   localparam int PIC_ADV_SHIFT = 2;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] PIC_OFS_SYSCTL = 8'h00;
   localparam logic [7:0] PIC_OFS_FLAGS = 8'h04;
   localparam logic [7:0] PIC_OFS_PRIO = 8'h08;
   localparam logic [7:0] PIC_OFS_ENABLE = 8'h0C;
   localparam logic [7:0] PIC_OFS_STATUS = 8'h10;
   localparam logic [7:0] PIC_OFS_PEND = 8'h14;
   // system control word bits
   localparam int PIC_SYS_SCHEME = 0;
   localparam int PIC_SYS_NMIEDGE = 1;
   localparam int PIC_SYS_ADVMODE = 2;
   // processor flags word bits
   localparam int PIC_FLG_MAIN = 0;
   localparam int PIC_FLG_USER = 1;
   localparam logic [2:0] PIC_SYS_RST = 3'h1;
   localparam logic [1:0] PIC_FLG_RST = 2'h1;
   localparam logic [7:0] PIC_PRIO_RST = 8'h00;
   localparam logic [31:0] PIC_ENA_RST = 32'h00000000;
   localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;
endpackage : pic_pkg

// file: tb/pic_core_model.sv
// Purpose: core-side partner that takes accepted interrupts
// Assumes: accept_valid is a level held until core_ack
// Notes: stall sets how long the current instruction runs
`timescale 1ns/1ps
module pic_core_model (
   // clock
   input wire logic aclk,
   // bench control
   input wire logic [3:0] stall,
   // controller side
   input wire logic accept_valid,
   output logic core_insn_end,
   output logic core_ack
);
   // ------------------------------------------------------------
   // instruction boundary and context save
   // ------------------------------------------------------------
   logic phase = 1'b0;
   // a slow core reaches a boundary only every other cycle
   always @(posedge aclk) begin
      phase <= ~phase;
      core_insn_end <= (stall == 4'h0) | phase;
   end
   initial begin
      core_ack <= 1'b0;
      forever begin
         @(posedge aclk iff accept_valid === 1'b1);
         // finish the insn, stack counter and flags, then fetch vector
         repeat (stall) @(posedge aclk);
         core_ack <= 1'b1;
         @(posedge aclk);
         core_ack <= 1'b0;
      end
   end
endmodule : pic_core_model

// file: tb/tb_prioritized_interrupt_controller.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model acks every acceptance; sources hold levels
// Notes: acceptances are compared against a queue of notes
`timescale 1ns/1ps
module tb_prioritized_interrupt_controller;
   import pic_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [1:0] OKR = PIC_RESP_OKAY;
   logic aclk = 1'b0, aresetn = 1'b0, nmi = 1'b1, av_q = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, avec, pr;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000, rdata, r;
   logic [31:0] seed = 32'h0000002E;
   logic awready, wready, bvalid, arready, rvalid, av, anmi, ie, ack;
   logic [1:0] bresp, rresp, flags;
   logic [PIC_NSRC-1:0] req = '0;
   logic [15:0] aaddr;
   logic [14:0] pend;
   logic [3:0] stall = 4'h0;
   logic [31:0] expq [$];
   int error_cnt = 0, checks = 0, w;

   always #10 aclk = ~aclk;

   pic_top i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .nmi_pin(nmi), .src_req(req), .core_insn_end(ie),
      .core_ack(ack), .accept_valid(av), .accept_nmi(anmi),
      .accept_vector(avec), .accept_vec_addr(aaddr),
      .processor_flags_word(flags)
   );
   pic_core_model i_core (
      .aclk(aclk), .stall(stall), .accept_valid(av),
      .core_insn_end(ie), .core_ack(ack)
   );
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function logic [31:0] xrand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xrand

   function logic [31:0] note(input logic n, input logic [7:0] v,
                              input logic adv);
      return {7'h00, n, v, adv ? {6'h00, v, 2'h0} : {7'h00, v, 1'h0}};
   endfunction : note

   // ties keep the earlier (smaller) vector
   function int winner(input logic [14:0] p, input logic [7:0] lv);
      int b;
      b = -1;
      for (int i = 0; i < PIC_NUSED; i++)
         if (p[i] && (b < 0 || lv[PIC_GRP_TAB[i]] > lv[PIC_GRP_TAB[b]]))
            b = i;
      return b;
   endfunction : winner

   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         aw_ok = aw_ok | (awready === 1'b1);
         w_ok = w_ok | (wready === 1'b1);
         awvalid <= ~aw_ok;
         wvalid <= ~w_ok;
      end while (!(aw_ok && w_ok));
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      check("rdata", ed, rdata);
      check("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd

   task automatic serviced();
      do @(posedge aclk); while (!(ack === 1'b1 && av === 1'b1));
   endtask : serviced

   // request held under one mask setting, released by another
   task automatic hold_go(input int i, input logic [1:0] hold,
                          input logic [1:0] go);
      wr(PIC_OFS_FLAGS, {30'h0, hold}, OKR);
      req[i] <= 1'b1;
      repeat (20) @(posedge aclk);
      rd(PIC_OFS_PEND, 32'h1 << i, OKR);
      expq.push_back(note(1'b0, PIC_VEC_TAB[i], 1'b0));
      wr(PIC_OFS_FLAGS, {30'h0, go}, OKR);
      serviced();
      req[i] <= 1'b0;
   endtask : hold_go

   task automatic report_and_stop();
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // monitor and watchdog
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      av_q <= av;
      if (av === 1'b1 && av_q !== 1'b1)
         check("accept", expq.size() ? expq.pop_front() : 32'hFFFFFFFF,
               {7'h00, anmi, avec, aaddr});
   end

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(PIC_OFS_SYSCTL, {29'h0, PIC_SYS_RST}, OKR);
      rd(PIC_OFS_FLAGS, {30'h0, PIC_FLG_RST}, OKR);
      rd(PIC_OFS_PRIO, {24'h0, PIC_PRIO_RST}, OKR);
      rd(8'hFC, 32'h00000000, PIC_RESP_SLVERR);
      wr(8'hFC, 32'h00000001, PIC_RESP_SLVERR);
      wr(PIC_OFS_ENABLE, 32'h0003FFFF, OKR);
      // every source alone, normal and advanced vector spacing
      for (int i = 0; i < PIC_NUSED; i++) begin
         r = xrand();
         stall <= {2'h0, r[1:0]};
         wr(PIC_OFS_SYSCTL, {29'h0, i[0], 2'h1}, OKR);
         expq.push_back(note(1'b0, PIC_VEC_TAB[i], i[0]));
         req[i] <= 1'b1;
         wr(PIC_OFS_FLAGS, 32'h00000000, OKR);
         serviced();
         req[i] <= 1'b0;
         rd(PIC_OFS_FLAGS, 32'h00000001, OKR);
         check("flags", 32'h00000001, {30'h0, flags});
      end
      wr(PIC_OFS_SYSCTL, 32'h00000001, OKR);
      // random groups of requests drained by rank
      for (int k = 0; k < 6; k++) begin
         r = xrand();
         pr = (k == 0) ? 8'h00 : (r[15:8] & 8'hCE);
         if (k > 0)
            wr(PIC_OFS_PRIO, {24'h0, pr}, OKR);
         pend = r[30:16] | 15'h4000;
         req <= {3'h0, pend};
         while (pend != 15'h0000) begin
            w = winner(pend, pr);
            expq.push_back(note(1'b0, PIC_VEC_TAB[w], 1'b0));
            wr(PIC_OFS_FLAGS, 32'h00000000, OKR);
            serviced();
            pend[w] = 1'b0;
            req[w] <= 1'b0;
         end
      end
      // masking under both schemes, timer3 at level 1
      wr(PIC_OFS_PRIO, 32'h00000080, OKR);
      hold_go(0, 2'h1, 2'h2);
      wr(PIC_OFS_SYSCTL, 32'h00000000, OKR);
      hold_go(6, 2'h1, 2'h2);
      hold_go(0, 2'h3, 2'h1);
      rd(PIC_OFS_FLAGS, 32'h00000003, OKR);
      check("flags", 32'h00000003, {30'h0, flags});
      // nonmaskable through full masks, both edges
      expq.push_back(note(1'b1, PIC_VEC_NMI, 1'b0));
      nmi <= 1'b0;
      serviced();
      wr(PIC_OFS_SYSCTL, 32'h00000006, OKR);
      expq.push_back(note(1'b1, PIC_VEC_NMI, 1'b1));
      nmi <= 1'b1;
      serviced();
      // disabled source and reserved lines must stay silent
      wr(PIC_OFS_ENABLE, 32'h0003FFFE, OKR);
      wr(PIC_OFS_FLAGS, 32'h00000000, OKR);
      req <= 18'h38001;
      repeat (30) @(posedge aclk);
      req <= '0;
      repeat (5) @(posedge aclk);
      rd(PIC_OFS_STATUS, {24'h0, PIC_VEC_NMI}, OKR);
      check("queue", 32'h00000000, expq.size());
      report_and_stop();
   end
endmodule : tb_prioritized_interrupt_controller
